// ---- design/timer_map.svh ----
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
// Behaviour
// - Edge count mode: each selected pin edge decrements the counter until it equals match.
// - Edge count accepts rising, falling or both edges, chosen by the edge select field.
// - On reaching match: set match flags, reload from interval load, clear timer enable.
// - After the target is reached, edges are ignored until software enables again.
// - Edge time counter free-runs down from interval load, which resets to 0xFFFF.
// - Capture select one enters edge time mode; edge select chooses the captured edge.
// - Each selected edge copies the count to the captured register and sets event flags.
// - The captured count holds until the next selected edge overwrites it.
// - Edge time counter keeps running after capture and reloads after reaching 0x0000.
// - Alternate mode select enables PWM; interval load defines the output period.
// - PWM offers an 8-bit prescaler with its own prescale match, giving 24 bits.
// - PWM counts to 0x0000, reloads counter and prescaler next cycle, until disabled.
// - PWM mode never raises any status flag.
// - PWM output asserts at the start value, drops at match; a bit inverts it.
// - Configuration 0x4 runs the two timers as independent 16-bit channels.
// - Mode field 0x1 is one-shot, stopping at timeout; 0x2 is periodic, running on.
// - Writing one to a clear bit of the interrupt clear register clears that flag.
// - Configuration 0x1 selects RTC mode, counting edges of the 32 kHz slow clock pin.
// - RTC count equal to match reloads zero and keeps counting; no clear needed.

`define CFG_OFF       12'h000
`define MODE_A_OFF    12'h004
`define CTL_OFF       12'h00C
`define IMR_OFF       12'h018
`define RIS_OFF       12'h01C
`define MIS_OFF       12'h020
`define ICR_OFF       12'h024
`define ILR_A_OFF     12'h028
`define MATCH_A_OFF   12'h030
`define PR_A_OFF      12'h038
`define PMR_A_OFF     12'h040
`define TR_A_OFF      12'h048

`define CFG_RTC       3'h1
`define CFG_16BIT     3'h4
`define MODE_ONESHOT  2'h1
`define MODE_PERIODIC 2'h2
`define MODE_CAPTURE  2'h3
`define EDGE_RISE     2'h0
`define EDGE_FALL     2'h1

`define CTL_STRIDE    8
`define ST_TO_BIT     0
`define ST_MATCH_BIT  1
`define ST_EVENT_BIT  2
`define ST_RTC_BIT    3
`define ST_STRIDE     8

`define ILR_RESET     16'hFFFF
`define MATCH_RESET   16'hFFFF
`define CAPTURE_RESET 16'hFFFF
`define RTC_START     32'h00000001
`endif

// ---- design/timer_pkg.sv ----
package timer_pkg;

    typedef enum logic [2:0]
    {
        OP_IDLE     = 3'b000,
        OP_ONESHOT  = 3'b001,
        OP_PERIODIC = 3'b010,
        OP_COUNT    = 3'b011,
        OP_TIME     = 3'b100,
        OP_PWM      = 3'b101
    } op_type;

    typedef struct packed
    {
        logic       alternate_mode_select;
        logic       capture_mode_select;
        logic [1:0] timer_mode_field;
    } mode_type;

    typedef struct packed
    {
        logic       pwm_invert_bit;
        logic [1:0] edge_select;
        logic       timer_enable_bit;
    } chan_ctl_type;

endpackage

// ---- design/timer_capture_pwm.sv ----
`include "timer_map.svh"

module timer_capture_pwm
#(
    parameter int TIMER_WIDTH    = 16,
    parameter int PRESCALE_WIDTH = 8
)
(
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [1:0]  CCP_IN,
    output logic      [1:0]  CCP_OUT,
    output logic      [1:0]  CCP_OE,
    input  wire logic        SLOW_CLOCK_PIN
);

    if (TIMER_WIDTH != 16 || PRESCALE_WIDTH != 8)
    begin : width_check
        $error("Only a 16-bit counter with an 8-bit prescaler is supported.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic timer_pkg::op_type op_decode(input logic [2:0] cfg_value,
                                                    input timer_pkg::mode_type m);
        timer_pkg::op_type op;
        op = timer_pkg::OP_IDLE;
        if (cfg_value[2])
        begin
            if (m.alternate_mode_select)
                op = timer_pkg::OP_PWM;
            else if (m.timer_mode_field == `MODE_ONESHOT)
                op = timer_pkg::OP_ONESHOT;
            else if (m.timer_mode_field == `MODE_PERIODIC)
                op = timer_pkg::OP_PERIODIC;
            else if (m.timer_mode_field == `MODE_CAPTURE)
                op = m.capture_mode_select ? timer_pkg::OP_TIME : timer_pkg::OP_COUNT;
        end
        return op;
    endfunction

    function automatic logic edge_pick(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            `EDGE_RISE: return rise;
            `EDGE_FALL: return fall;
            default:    return rise | fall;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic [2:0]                cfg;
    timer_pkg::mode_type       mode     [2];
    timer_pkg::chan_ctl_type   ctl      [2];
    logic [15:0]               ilr      [2];
    logic [15:0]               match    [2];
    logic [7:0]                pr       [2];
    logic [7:0]                pmr      [2];
    logic [15:0]               cnt      [2];
    logic [7:0]                pre      [2];
    logic [15:0]               captured [2];
    logic [15:0]               imr;
    logic [1:0]                flag_to;
    logic [1:0]                flag_match;
    logic [1:0]                flag_event;
    logic                      flag_rtc;
    logic [31:0]               rtc_count;
    logic [1:0]                ilr_load;
    logic [1:0]                pwm_raw;
    logic [1:0]                ccp_s1;
    logic [1:0]                ccp_s2;
    logic [1:0]                ccp_s3;
    logic                      slow_s1;
    logic                      slow_s2;
    logic                      slow_s3;

    timer_pkg::op_type         op       [2];
    logic [1:0]                running;
    logic [1:0]                edge_hit;
    logic [1:0]                timeout;
    logic [1:0]                count_hit;
    logic [1:0]                capture;
    logic [1:0]                stop_req;
    logic [1:0]                wr_mode;
    logic [1:0]                wr_ilr;
    logic [1:0]                wr_match;
    logic [1:0]                wr_pr;
    logic [1:0]                wr_pmr;
    logic [31:0]               ris_word;
    logic [31:0]               ctl_word;
    logic [31:0]               rd_value;
    logic                      addr_hit;
    logic                      wr_en;
    logic                      rtc_mode;
    logic                      rtc_tick;
    logic                      rtc_hit;
    logic                      cfg_rtc_load;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode.

    assign wr_en        = PSEL && PENABLE && PWRITE && PREADY && addr_hit;
    assign rtc_mode     = (cfg == `CFG_RTC);
    assign rtc_tick     = slow_s2 && !slow_s3;
    assign rtc_hit      = rtc_mode && ctl[0].timer_enable_bit && rtc_tick
                          && rtc_count == {match[1], match[0]};
    assign cfg_rtc_load = wr_en && PADDR == `CFG_OFF && PWDATA[2:0] == `CFG_RTC;

    for (genvar n = 0; n < 2; n++)
    begin : chan
        assign op[n]        = op_decode(cfg, mode[n]);
        assign running[n]   = ctl[n].timer_enable_bit && op[n] != timer_pkg::OP_IDLE;
        assign edge_hit[n]  = edge_pick(ctl[n].edge_select, ccp_s2[n] && !ccp_s3[n],
                                        !ccp_s2[n] && ccp_s3[n]);
        assign timeout[n]   = running[n] && !ilr_load[n] && pre[n] == 8'h00 && cnt[n] == 16'h0000
                              && (op[n] == timer_pkg::OP_ONESHOT || op[n] == timer_pkg::OP_PERIODIC);
        assign count_hit[n] = running[n] && !ilr_load[n] && op[n] == timer_pkg::OP_COUNT
                              && edge_hit[n] && 16'(cnt[n] - 16'h0001) == match[n];
        assign capture[n]   = running[n] && op[n] == timer_pkg::OP_TIME && edge_hit[n];
        assign stop_req[n]  = count_hit[n] || (timeout[n] && op[n] == timer_pkg::OP_ONESHOT);
        assign wr_mode[n]   = wr_en && PADDR == 12'(`MODE_A_OFF + 4 * n);
        assign wr_ilr[n]    = wr_en && PADDR == 12'(`ILR_A_OFF + 4 * n);
        assign wr_match[n]  = wr_en && PADDR == 12'(`MATCH_A_OFF + 4 * n);
        assign wr_pr[n]     = wr_en && PADDR == 12'(`PR_A_OFF + 4 * n);
        assign wr_pmr[n]    = wr_en && PADDR == 12'(`PMR_A_OFF + 4 * n);
    end

    always_comb
    begin
        ris_word = 32'h00000000;
        ctl_word = 32'h00000000;
        for (int n = 0; n < 2; n++)
        begin
            ris_word[`ST_TO_BIT + `ST_STRIDE * n]    = flag_to[n];
            ris_word[`ST_MATCH_BIT + `ST_STRIDE * n] = flag_match[n];
            ris_word[`ST_EVENT_BIT + `ST_STRIDE * n] = flag_event[n];
            ctl_word[`CTL_STRIDE * n +: 4]           = ctl[n];
        end
        ris_word[`ST_RTC_BIT] = flag_rtc;
    end

    always_comb
    begin
        addr_hit = 1'b1;
        case (PADDR)
            `CFG_OFF:             rd_value = {29'h0, cfg};
            `MODE_A_OFF:          rd_value = {28'h0, mode[0]};
            `MODE_A_OFF + 12'h4:  rd_value = {28'h0, mode[1]};
            `CTL_OFF:             rd_value = ctl_word;
            `IMR_OFF:             rd_value = {16'h0, imr};
            `RIS_OFF:             rd_value = ris_word;
            `MIS_OFF:             rd_value = ris_word & {16'h0, imr};
            `ICR_OFF:             rd_value = 32'h00000000;
            `ILR_A_OFF:           rd_value = {16'h0, ilr[0]};
            `ILR_A_OFF + 12'h4:   rd_value = {16'h0, ilr[1]};
            `MATCH_A_OFF:         rd_value = {16'h0, match[0]};
            `MATCH_A_OFF + 12'h4: rd_value = {16'h0, match[1]};
            `PR_A_OFF:            rd_value = {24'h0, pr[0]};
            `PR_A_OFF + 12'h4:    rd_value = {24'h0, pr[1]};
            `PMR_A_OFF:           rd_value = {24'h0, pmr[0]};
            `PMR_A_OFF + 12'h4:   rd_value = {24'h0, pmr[1]};
            `TR_A_OFF:            rd_value = rtc_mode ? {16'h0, rtc_count[15:0]} :
                                             op[0] == timer_pkg::OP_TIME ? {16'h0, captured[0]} :
                                             {16'h0, cnt[0]};
            `TR_A_OFF + 12'h4:    rd_value = rtc_mode ? {16'h0, rtc_count[31:16]} :
                                             op[1] == timer_pkg::OP_TIME ? {16'h0, captured[1]} :
                                             {16'h0, cnt[1]};
            default:
            begin
                rd_value = 32'h00000000;
                addr_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait-free access; the answer is prepared in the setup cycle.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h00000000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL && !PENABLE;
            if (PSEL && !PENABLE)
            begin
                PRDATA  <= PWRITE ? 32'h00000000 : rd_value;
                PSLVERR <= !addr_hit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers. A software write to control wins over the hardware stop.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cfg <= 3'h0;
            imr <= 16'h0000;
            for (int n = 0; n < 2; n++)
            begin
                mode[n]     <= '0;
                ctl[n]      <= '0;
                ilr[n]      <= `ILR_RESET;
                match[n]    <= `MATCH_RESET;
                pr[n]       <= 8'h00;
                pmr[n]      <= 8'h00;
                ilr_load[n] <= 1'b0;
            end
        end
        else
        begin
            if (wr_en && PADDR == `CFG_OFF)
                cfg <= PWDATA[2:0];
            if (wr_en && PADDR == `IMR_OFF)
                imr <= PWDATA[15:0];
            for (int n = 0; n < 2; n++)
            begin
                ilr_load[n] <= wr_ilr[n];
                if (wr_mode[n])
                    mode[n] <= timer_pkg::mode_type'(PWDATA[3:0]);
                if (wr_en && PADDR == `CTL_OFF)
                    ctl[n] <= timer_pkg::chan_ctl_type'(PWDATA[`CTL_STRIDE * n +: 4]);
                else if (stop_req[n])
                    ctl[n].timer_enable_bit <= 1'b0;
                if (wr_ilr[n])
                    ilr[n] <= PWDATA[15:0];
                if (wr_match[n])
                    match[n] <= PWDATA[15:0];
                if (wr_pr[n])
                    pr[n] <= PWDATA[7:0];
                if (wr_pmr[n])
                    pmr[n] <= PWDATA[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ccp_s1  <= 2'b00;
            ccp_s2  <= 2'b00;
            ccp_s3  <= 2'b00;
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
            slow_s3 <= 1'b0;
        end
        else
        begin
            ccp_s1  <= CCP_IN;
            ccp_s2  <= ccp_s1;
            ccp_s3  <= ccp_s2;
            slow_s1 <= SLOW_CLOCK_PIN;
            slow_s2 <= slow_s1;
            slow_s3 <= slow_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counters. A disabled channel rests at its start value.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int n = 0; n < 2; n++)
            begin
                cnt[n]      <= `ILR_RESET;
                pre[n]      <= 8'h00;
                captured[n] <= `CAPTURE_RESET;
            end
        end
        else
        begin
            for (int n = 0; n < 2; n++)
            begin
                if (capture[n])
                    captured[n] <= cnt[n];
                if (!running[n] || ilr_load[n])
                begin
                    cnt[n] <= ilr[n];
                    pre[n] <= pr[n];
                end
                else
                begin
                    case (op[n])
                        timer_pkg::OP_ONESHOT, timer_pkg::OP_PERIODIC, timer_pkg::OP_PWM:
                        begin
                            if (pre[n] != 8'h00)
                                pre[n] <= 8'(pre[n] - 8'h01);
                            else
                            begin
                                pre[n] <= pr[n];
                                cnt[n] <= (cnt[n] == 16'h0000) ? ilr[n] : 16'(cnt[n] - 16'h0001);
                            end
                        end
                        timer_pkg::OP_COUNT:
                        begin
                            if (edge_hit[n])
                                cnt[n] <= count_hit[n] ? ilr[n] : 16'(cnt[n] - 16'h0001);
                        end
                        timer_pkg::OP_TIME:
                            cnt[n] <= (cnt[n] == 16'h0000) ? ilr[n] : 16'(cnt[n] - 16'h0001);
                        default:
                            cnt[n] <= cnt[n];
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status; a new event in the clearing cycle survives the clear.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            flag_to    <= 2'b00;
            flag_match <= 2'b00;
            flag_event <= 2'b00;
            flag_rtc   <= 1'b0;
        end
        else
        begin
            for (int n = 0; n < 2; n++)
            begin
                flag_to[n]    <= timeout[n] || (flag_to[n]
                                 && !(wr_en && PADDR == `ICR_OFF && PWDATA[`ST_TO_BIT + `ST_STRIDE * n]));
                flag_match[n] <= count_hit[n] || (flag_match[n]
                                 && !(wr_en && PADDR == `ICR_OFF && PWDATA[`ST_MATCH_BIT + `ST_STRIDE * n]));
                flag_event[n] <= capture[n] || (flag_event[n]
                                 && !(wr_en && PADDR == `ICR_OFF && PWDATA[`ST_EVENT_BIT + `ST_STRIDE * n]));
            end
            flag_rtc <= rtc_hit || (flag_rtc && !(wr_en && PADDR == `ICR_OFF && PWDATA[`ST_RTC_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slow-clock counter, counting up on each synchronised rising edge.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            rtc_count <= `RTC_START;
        else if (cfg_rtc_load)
            rtc_count <= `RTC_START;
        else if (rtc_mode && ctl[0].timer_enable_bit && rtc_tick)
            rtc_count <= rtc_hit ? 32'h00000000 : 32'(rtc_count + 32'h00000001);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pulse-width output.

    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pwm_raw <= 2'b00;
            CCP_OUT <= 2'b00;
            CCP_OE  <= 2'b00;
        end
        else
        begin
            for (int n = 0; n < 2; n++)
            begin
                if (op[n] != timer_pkg::OP_PWM || !running[n])
                    pwm_raw[n] <= 1'b0;
                else if (cnt[n] == ilr[n] && pre[n] == pr[n])
                    pwm_raw[n] <= 1'b1;
                else if (cnt[n] == match[n] && pre[n] == pmr[n])
                    pwm_raw[n] <= 1'b0;
                CCP_OUT[n] <= pwm_raw[n] ^ ctl[n].pwm_invert_bit;
                CCP_OE[n]  <= (op[n] == timer_pkg::OP_PWM);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    for (genvar n = 0; n < 2; n++)
    begin : chk
        sequence pwm_start_s;
            op[n] == timer_pkg::OP_PWM && running[n] && !ilr_load[n] && cnt[n] == ilr[n] && pre[n] == pr[n];
        endsequence

        sequence count_done_s;
            count_hit[n] && !(wr_en && PADDR == `CTL_OFF);
        endsequence

        a_count_step: assert property (running[n] && op[n] == timer_pkg::OP_COUNT && edge_hit[n] && !ilr_load[n]
            && !count_hit[n] |=> cnt[n] == 16'($past(cnt[n]) - 16'h0001))
            else $error("Edge count did not step down by one.");
        a_count_stop: assert property (count_done_s |=> !ctl[n].timer_enable_bit && flag_match[n]
            && cnt[n] == $past(ilr[n]))
            else $error("Edge count target did not stop and reload the channel.");
        a_edges_ignored: assert property (!ctl[n].timer_enable_bit |=> cnt[n] == $past(ilr[n]))
            else $error("An edge was acted on while the channel was disabled.");
        a_capture_copy: assert property (capture[n] |=> captured[n] == $past(cnt[n]) && flag_event[n])
            else $error("Captured count or event flag wrong after an edge.");
        a_capture_hold: assert property (!capture[n] |=> $stable(captured[n]))
            else $error("Captured count changed without an edge.");
        a_time_wrap: assert property (running[n] && op[n] == timer_pkg::OP_TIME && !ilr_load[n]
            && cnt[n] == 16'h0000 |=> cnt[n] == $past(ilr[n]))
            else $error("Edge time counter did not reload after zero.");
        a_pwm_quiet: assert property (op[n] == timer_pkg::OP_PWM
            |=> !$rose(flag_to[n]) && !$rose(flag_match[n]) && !$rose(flag_event[n]))
            else $error("A status event was raised in pulse-width mode.");
        a_pwm_start: assert property (pwm_start_s ##1 (op[n] == timer_pkg::OP_PWM && $stable(ctl[n]))
            |=> CCP_OUT[n] == !$past(ctl[n].pwm_invert_bit))
            else $error("Pulse-width output not asserted at the start value.");
        a_oneshot_stop: assert property (timeout[n] && op[n] == timer_pkg::OP_ONESHOT
            && !(wr_en && PADDR == `CTL_OFF) |=> !ctl[n].timer_enable_bit && flag_to[n])
            else $error("One-shot timer kept running after timeout.");
    end

    a_rtc_wrap: assert property (rtc_hit && !cfg_rtc_load |=> rtc_count == 32'h00000000 && flag_rtc)
        else $error("Slow-clock counter did not roll over at match.");
    a_clear_race: assert property (timeout[0] && wr_en && PADDR == `ICR_OFF |=> flag_to[0])
        else $error("A timeout arriving with its clear was lost.");

endmodule

// ---- test/ccp_source.sv ----
module ccp_source
(
    input  wire logic       clk,
    input  wire logic [1:0] tog,
    output logic      [1:0] pin,
    output logic            slow
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        pin = 2'h0;
        slow = 1'b0;
    end
    // Each request bit flips its pin once, so one request is one edge.
    always @(posedge clk) pin <= pin ^ tog;
    // Free-running 32 kHz slow clock, unrelated in phase to the system clock.
    always #15625 slow = ~slow;
endmodule

// ---- test/timer_capture_pwm_modes_tb.sv ----
`include "timer_map.svh"
`define CHK(g, e) chk((g) === (e))

module timer_capture_pwm_modes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        MCLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, SLOW, er;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, rd1;
    logic [1:0]  CCP_IN, CCP_OUT, CCP_OE, tog = 2'h0;
    int          errors = 0, num_checks = 0, cyc = 0, n, p, m, hi, e;
    always #2 MCLK = ~MCLK;
    ccp_source src (.clk(MCLK), .tog(tog), .pin(CCP_IN), .slow(SLOW));
    timer_capture_pwm DUT (.MCLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
        .PSLVERR, .CCP_IN, .CCP_OUT, .CCP_OE, .SLOW_CLOCK_PIN(SLOW));
    task automatic chk(input bit ok);
        num_checks++;
        if (!ok)
        begin
            errors++;
            $display("[ERR] %0t value mismatch", $time);
        end
    endtask
    task automatic test_done;
        $display("errors=%0d checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge MCLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            test_done;
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic edges(input int k);
        repeat (k)
        begin
            @(posedge MCLK);
            tog <= 2'h1;
            @(posedge MCLK);
            tog <= 2'h0;
            repeat (5) @(posedge MCLK);
        end
    endtask
    task automatic pwm_high(input logic [31:0] c);
        apb(1, `CTL_OFF, c & 32'hFFFFFEFF);
        apb(1, `CTL_OFF, c);
        repeat (p + 8) @(posedge MCLK);
        hi = 0;
        repeat (2 * (p + 1)) @(posedge MCLK) hi += int'(CCP_OUT[1]);
    endtask
    initial
    begin
        n = $urandom(32'h4E78);
        // At least two targets, so the single-edge-type runs stay below the target.
        n = $urandom_range(8, 2);
        p = $urandom_range(40, 8);
        m = $urandom_range(p - 1, 1);
        repeat (3) @(posedge MCLK);
        RSTN <= 1'b1;
        apb(0, `ILR_A_OFF, 32'h0);
        `CHK(rd, 32'h0000FFFF);
        apb(0, 12'h0FC, 32'h0);
        `CHK(er, 1'b1);
        apb(1, `CFG_OFF, 32'h4);
        apb(1, `MODE_A_OFF, 32'h3);
        for (e = 0; e < 3; e++)
        begin
            apb(1, `CTL_OFF, e << 1);
            apb(1, `ILR_A_OFF, 6 + 2 * n);
            apb(1, `MATCH_A_OFF, 32'h6);
            apb(1, `CTL_OFF, (e << 1) | 1);
            edges(2 * n + 2);
            apb(0, `TR_A_OFF, 32'h0);
            `CHK(rd, (e < 2) ? 6 + n - 1 : 6 + 2 * n);
            apb(0, `RIS_OFF, 32'h0);
            `CHK(rd, (e < 2) ? 32'h0 : 32'h2);
            apb(1, `ICR_OFF, 32'h2);
        end
        apb(0, `RIS_OFF, 32'h0);
        `CHK(rd, 32'h0);
        apb(1, `CTL_OFF, 32'h0);
        apb(1, `MODE_A_OFF, 32'h7);
        apb(1, `ILR_A_OFF, 32'hFFFF);
        apb(1, `IMR_OFF, 32'h4);
        apb(1, `CTL_OFF, 32'h1);
        edges(1 + CCP_IN[0]);
        apb(0, `MIS_OFF, 32'h0);
        `CHK(rd, 32'h4);
        apb(0, `TR_A_OFF, 32'h0);
        rd1 = rd;
        edges(1);
        apb(0, `TR_A_OFF, 32'h0);
        `CHK(rd, rd1);
        // Four clocks lie between enable and the capture: pin request, two synchroniser stages, compare.
        `CHK(rd1, 32'h0000FFFB);
        edges(1);
        apb(0, `TR_A_OFF, 32'h0);
        `CHK(rd != rd1, 1'b1);
        apb(1, `CTL_OFF, 32'h0);
        apb(1, `ICR_OFF, 32'hFFFF);
        apb(1, 12'h008, 32'hA);
        apb(1, 12'h02C, p);
        apb(1, 12'h034, m);
        pwm_high(32'h100);
        `CHK(hi, 2 * (p - m));
        `CHK(CCP_OE[1], 1'b1);
        apb(0, `RIS_OFF, 32'h0);
        `CHK(rd, 32'h0);
        pwm_high(32'h900);
        `CHK(hi, 2 * (m + 1));
        apb(1, `CTL_OFF, 32'h0);
        for (e = 1; e < 3; e++)
        begin
            apb(1, `MODE_A_OFF, e);
            apb(1, `ILR_A_OFF, 32'h5);
            apb(1, `CTL_OFF, 32'h1);
            repeat (20) @(posedge MCLK);
            apb(0, `CTL_OFF, 32'h0);
            `CHK(rd, e - 1);
            apb(0, `RIS_OFF, 32'h0);
            `CHK(rd, 32'h1);
            apb(1, `CTL_OFF, 32'h0);
            apb(1, `ICR_OFF, 32'h1);
        end
        apb(1, `CFG_OFF, 32'h1);
        apb(1, `MATCH_A_OFF, 32'h1);
        apb(1, 12'h034, 32'h0);
        // Enabling half a slow period before its rising edge keeps a stale edge out of the count.
        @(negedge SLOW);
        apb(1, `CTL_OFF, 32'h1);
        @(posedge SLOW);
        repeat (8) @(posedge MCLK);
        apb(0, `RIS_OFF, 32'h0);
        `CHK(rd, 32'h8);
        apb(0, `TR_A_OFF, 32'h0);
        `CHK(rd, 32'h0);
        test_done;
    end
endmodule
